//--- tw_master_seq.v
// two-wire master state sequencer with receive byte FIFO
// assumes scl and sda are open-drain wires resolved outside
// and that software drives control levels on the core clock
`timescale 1ns/100ps
`include "tw_seq_consts.vh"

// ============================================================
// fifo with valid/ready on both sides
module tw_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk_in,
	input wire reset_n_in,
	input wire in_valid_in,
	input wire [WIDTH-1:0] in_data_in,
	output wire in_ready_out,
	output wire out_valid_out,
	output wire [WIDTH-1:0] out_data_out,
	input wire out_ready_in
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	// handshake flags
	assign in_ready_out = (count != DEPTH[AW:0]);
	assign out_valid_out = (count != {(AW+1){1'b0}});
	assign out_data_out = mem[rd_ptr];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	// storage write
	always @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// pointers and fill count
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// ============================================================
// master sequencer
module tw_master_seq #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire clk_in,
	input wire reset_n_in,
	input wire unit_enable_in,
	input wire begin_request_in,
	input wire bus_release_set_in,
	input wire ack_enable_in,
	input wire [2:0] rate_select_in,
	input wire flag_clear_in,
	input wire buffer_write_in,
	input wire [7:0] buffer_data_in,
	input wire scl_in,
	input wire sda_in,
	input wire rx_ready_in,
	output wire scl_out,
	output reg scl_oe_out,
	output wire sda_out,
	output reg sda_oe_out,
	output reg transfer_event_flag_out,
	output reg bus_release_request_out,
	output reg [7:0] bus_state_code_out,
	output reg [7:0] shift_byte_buffer_out,
	output reg controller_receive_out,
	output reg bus_busy_out,
	output wire rx_valid_out,
	output wire [7:0] rx_data_out
);
	// one-hot states
	localparam S_IDLE = 6'b000001;
	localparam S_WFREE = 6'b000010;
	localparam S_START = 6'b000100;
	localparam S_HOLD = 6'b001000;
	localparam S_XFER = 6'b010000;
	localparam S_STOP = 6'b100000;

	reg [5:0] state;
	reg scl_meta;
	reg scl_s;
	reg sda_meta;
	reg sda_s;
	reg scl_p;
	reg sda_p;
	reg [15:0] tick_cnt;
	reg [1:0] q;
	reg [3:0] bit_n;
	reg is_addr;
	reg ack_send;
	reg lost;
	reg repeated;
	reg push;
	wire tick;
	wire fifo_ready;
	wire [15:0] qtr_cycles;

	// quarter-bit length in core cycles for a rate in kHz
	function [15:0] qtr_of;
		input [15:0] khz;
		integer full;
		begin
			full = `TW_CLK_KHZ / (`TW_QTR_PER_BIT * khz);
			qtr_of = full[15:0]; // rate table keeps this in 16 bits
		end
	endfunction

	// rate table lookup
	function [15:0] rate_qtr;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: rate_qtr = qtr_of(`TW_RATE0_KHZ);
				3'h1: rate_qtr = qtr_of(`TW_RATE1_KHZ);
				3'h2: rate_qtr = qtr_of(`TW_RATE2_KHZ);
				3'h3: rate_qtr = qtr_of(`TW_RATE3_KHZ);
				3'h4: rate_qtr = qtr_of(`TW_RATE4_KHZ);
				3'h5: rate_qtr = qtr_of(`TW_RATE5_KHZ);
				3'h6: rate_qtr = qtr_of(`TW_RATE6_KHZ);
				default: rate_qtr = qtr_of(`TW_RATE7_KHZ);
			endcase
		end
	endfunction

	// open-drain pins only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign qtr_cycles = rate_qtr(rate_select_in);
	assign tick = (tick_cnt == 16'h0000);

	// ============================================================
	// receive byte buffer, back-pressure stalls next receive
	tw_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_rx_fifo (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(push),
		.in_data_in(shift_byte_buffer_out),
		.in_ready_out(fifo_ready),
		.out_valid_out(rx_valid_out),
		.out_data_out(rx_data_out),
		.out_ready_in(rx_ready_in)
	);

	// ============================================================
	// pin synchronisers and bus free detector
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scl_meta <= 1'b1;
			scl_s <= 1'b1;
			sda_meta <= 1'b1;
			sda_s <= 1'b1;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			bus_busy_out <= 1'b0;
		end else begin
			scl_meta <= scl_in;
			scl_s <= scl_meta;
			sda_meta <= sda_in;
			sda_s <= sda_meta;
			scl_p <= scl_s;
			sda_p <= sda_s;
			if (scl_s && scl_p && sda_p && !sda_s) begin
				bus_busy_out <= 1'b1; // start seen
			end else if (scl_s && scl_p && !sda_p && sda_s) begin
				bus_busy_out <= 1'b0; // stop seen
			end
		end
	end

	// quarter-bit tick divider, one-cycle enable
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_cnt <= 16'h0000;
		end else if (tick) begin
			tick_cnt <= qtr_cycles - 16'h0001;
		end else begin
			tick_cnt <= tick_cnt - 16'h0001;
		end
	end

	// ============================================================
	// sequencer
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= S_IDLE;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
			transfer_event_flag_out <= 1'b0;
			bus_release_request_out <= 1'b0;
			bus_state_code_out <= `TW_ST_IDLE;
			shift_byte_buffer_out <= 8'h00;
			controller_receive_out <= 1'b0;
			q <= `TW_Q0;
			bit_n <= 4'h0;
			is_addr <= 1'b0;
			ack_send <= 1'b0;
			lost <= 1'b0;
			repeated <= 1'b0;
			push <= 1'b0;
		end else begin
			push <= 1'b0;
			// software clears; later sets in this cycle win
			if (flag_clear_in) begin
				transfer_event_flag_out <= 1'b0;
			end
			if (bus_release_set_in) begin
				bus_release_request_out <= 1'b1;
			end
			if (buffer_write_in && state != S_XFER) begin
				shift_byte_buffer_out <= buffer_data_in;
			end
			if (!unit_enable_in) begin
				state <= S_IDLE;
				scl_oe_out <= 1'b0;
				sda_oe_out <= 1'b0;
				lost <= 1'b0;
			end else begin
				case (state)
					S_IDLE: begin
						scl_oe_out <= 1'b0;
						sda_oe_out <= 1'b0;
						if (begin_request_in && !transfer_event_flag_out) begin
							state <= S_WFREE;
						end
					end
					// wait for a free bus before a fresh start
					S_WFREE: begin
						scl_oe_out <= 1'b0;
						sda_oe_out <= 1'b0;
						lost <= 1'b0;
						if (!bus_busy_out && tick) begin
							repeated <= 1'b0;
							q <= `TW_Q0;
							state <= S_START;
						end
					end
					// start or repeated start
					S_START: begin
						if (tick) begin
							case (q)
								`TW_Q0: begin
									sda_oe_out <= 1'b0;
									q <= `TW_Q1;
								end
								`TW_Q1: begin
									scl_oe_out <= 1'b0;
									q <= `TW_Q2;
								end
								`TW_Q2: begin
									if (scl_s) begin
										sda_oe_out <= 1'b1;
										q <= `TW_Q3;
									end
								end
								default: begin
									scl_oe_out <= 1'b1;
									transfer_event_flag_out <= 1'b1;
									bus_state_code_out <= repeated ?
										`TW_ST_RSTART : `TW_ST_START;
									state <= S_HOLD;
								end
							endcase
						end
					end
					// suspended until software clears the flag
					S_HOLD: begin
						scl_oe_out <= !lost;
						q <= `TW_Q0;
						bit_n <= 4'h0;
						if (!transfer_event_flag_out && !flag_clear_in) begin
							case (bus_state_code_out)
								`TW_ST_ARB_LOST: begin
									if (begin_request_in) begin
										state <= S_WFREE;
									end else begin
										state <= S_IDLE;
									end
								end
								`TW_ST_START, `TW_ST_RSTART: begin
									is_addr <= 1'b1;
									state <= S_XFER;
								end
								default: begin
									if (bus_release_request_out) begin
										state <= S_STOP;
									end else if (begin_request_in) begin
										repeated <= 1'b1;
										state <= S_START;
									end else if (!controller_receive_out) begin
										is_addr <= 1'b0;
										state <= S_XFER;
									end else if (bus_state_code_out == `TW_ST_AR_ACK ||
										bus_state_code_out == `TW_ST_DR_ACK) begin
										if (fifo_ready) begin
											is_addr <= 1'b0;
											ack_send <= ack_enable_in;
											state <= S_XFER;
										end
									end else begin
										state <= S_STOP;
									end
								end
							endcase
						end
					end
					// eight data bits plus acknowledge bit
					S_XFER: begin
						if (tick) begin
							case (q)
								`TW_Q0: begin
									if (bit_n == `TW_ACK_BIT) begin
										sda_oe_out <= controller_receive_out &&
											!is_addr && ack_send;
									end else if (is_addr || !controller_receive_out) begin
										sda_oe_out <= !shift_byte_buffer_out[`TW_MSB];
									end else begin
										sda_oe_out <= 1'b0;
									end
									q <= `TW_Q1;
								end
								`TW_Q1: begin
									scl_oe_out <= 1'b0;
									q <= `TW_Q2;
								end
								`TW_Q2: begin
									if (scl_s) begin
										q <= `TW_Q3;
										if (bit_n != `TW_ACK_BIT) begin
											shift_byte_buffer_out <=
												{shift_byte_buffer_out[6:0], sda_s};
										end
										// released line pulled low by another master
										if (!sda_oe_out && !sda_s &&
											((bit_n != `TW_ACK_BIT &&
											(is_addr || !controller_receive_out)) ||
											(bit_n == `TW_ACK_BIT &&
											controller_receive_out && !is_addr))) begin
											lost <= 1'b1;
											scl_oe_out <= 1'b0;
											transfer_event_flag_out <= 1'b1;
											bus_state_code_out <= `TW_ST_ARB_LOST;
											state <= S_HOLD;
										end else if (bit_n == `TW_ACK_BIT) begin
											ack_send <= !sda_s;
										end
									end
								end
								default: begin
									// data wire moves only in Q0, clock low
									scl_oe_out <= 1'b1;
									q <= `TW_Q0;
									if (bit_n != `TW_ACK_BIT) begin
										bit_n <= bit_n + 4'h1;
									end else begin
										transfer_event_flag_out <= 1'b1;
										state <= S_HOLD;
										if (is_addr) begin
											controller_receive_out <=
												shift_byte_buffer_out[`TW_RW_BIT];
											if (shift_byte_buffer_out[`TW_RW_BIT]) begin
												bus_state_code_out <= ack_send ?
													`TW_ST_AR_ACK : `TW_ST_AR_NACK;
											end else begin
												bus_state_code_out <= ack_send ?
													`TW_ST_AW_ACK : `TW_ST_AW_NACK;
											end
										end else if (controller_receive_out) begin
											push <= 1'b1;
											bus_state_code_out <= ack_send ?
												`TW_ST_DR_ACK : `TW_ST_DR_NACK;
										end else begin
											bus_state_code_out <= ack_send ?
												`TW_ST_DW_ACK : `TW_ST_DW_NACK;
										end
									end
								end
							endcase
						end
					end
					// stop, then optional fresh start
					S_STOP: begin
						if (tick) begin
							case (q)
								`TW_Q0: begin
									sda_oe_out <= 1'b1;
									q <= `TW_Q1;
								end
								`TW_Q1: begin
									scl_oe_out <= 1'b0;
									q <= `TW_Q2;
								end
								`TW_Q2: begin
									if (scl_s) begin
										q <= `TW_Q3;
									end
								end
								default: begin
									sda_oe_out <= 1'b0;
									if (!bus_release_set_in) begin
										bus_release_request_out <= 1'b0;
									end
									bus_state_code_out <= `TW_ST_IDLE;
									if (begin_request_in) begin
										state <= S_WFREE;
									end else begin
										state <= S_IDLE;
									end
								end
							endcase
						end
					end
					default: begin
						state <= S_IDLE;
					end
				endcase
			end
		end
	end
endmodule

//--- tw_master_seq_tb.sv
// self-checking bench for the two-wire master sequencer
// assumes the slave model and the port checker compile first
`timescale 1ns/100ps
// ============================================================
// bench top
module tw_master_seq_tb;
	reg clk, rst_n, en, breq, brel, ack_en, clr, bw, rx_rdy, comp;
	reg ack_a, ack_d;
	reg [2:0] rate;
	reg [7:0] bdata, a, d;
	reg [7:0] exq[$];
	integer seed, fail_count, samples_checked, t, i, n;
	wire scl_oe, sda_oe, flag, brr, crx, busy, rxv, s_oe;
	wire [7:0] code, rxd, got, sbb;
	// open-drain wires with pull-ups
	wire scl = !scl_oe;
	wire sda = !(sda_oe || s_oe || comp);
	tw_master_seq dut (.clk_in(clk), .reset_n_in(rst_n),
		.unit_enable_in(en), .begin_request_in(breq),
		.bus_release_set_in(brel), .ack_enable_in(ack_en),
		.rate_select_in(rate), .flag_clear_in(clr), .buffer_write_in(bw),
		.buffer_data_in(bdata), .scl_in(scl), .sda_in(sda),
		.rx_ready_in(rx_rdy), .scl_out(), .scl_oe_out(scl_oe), .sda_out(),
		.sda_oe_out(sda_oe), .transfer_event_flag_out(flag),
		.bus_release_request_out(brr), .bus_state_code_out(code),
		.shift_byte_buffer_out(sbb), .controller_receive_out(crx),
		.bus_busy_out(busy), .rx_valid_out(rxv), .rx_data_out(rxd));
	tw_slave_model slv (.scl_in(scl), .sda_in(sda), .ack_addr_in(ack_a),
		.ack_data_in(ack_d), .sda_oe_out(s_oe), .got_out(got));
	// core clock
	initial begin
		clk = 0;
		forever #25 clk = !clk;
	end
	// ============================================================
	// helpers
	function integer bit_cyc(input [2:0] r);
		bit_cyc = 20000 / ((64'h0A14_1928_323C_5064 >> (8 * r)) & 255);
	endfunction
	function [7:0] rdv(input integer k);
		rdv = 8'h35 + 8'h1D * k[7:0];
	endfunction
	task close_out;
		begin
			$display("checked %0d bad %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task check(input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("BAD %0t seen %h wanted %h", $time, seen, exp);
			end
		end
	endtask
	task tick;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task lim(input integer k, input integer m);
		begin
			if (k >= m) begin
				fail_count = fail_count + 1;
				$display("BAD %0t wait ran out", $time);
				close_out;
			end
		end
	endtask
	task wait_flag;
		integer k;
		begin
			k = 0;
			while (flag !== 1'b1 && k < 30000) begin
				tick;
				k = k + 1;
			end
			lim(k, 30000);
		end
	endtask
	// load, request release, then clear the flag
	task go(input ld, input [7:0] b, input rel);
		begin
			bdata = b;
			bw = ld;
			brel = rel;
			tick;
			bw = 0;
			brel = 0;
			clr = 1;
			tick;
			clr = 0;
		end
	endtask
	task step(input ld, input [7:0] b, input rel, input [7:0] exp);
		begin
			go(ld, b, rel);
			wait_flag;
			check(code, exp);
		end
	endtask
	task rx_wait(input [7:0] exp);
		begin
			wait_flag;
			check(code, exp);
			check(sbb, rdv(n));
			exq.push_back(rdv(n));
			n = n + 1;
		end
	endtask
	task rxb(input [7:0] exp);
		begin
			go(0, 0, 0);
			rx_wait(exp);
		end
	endtask
	task drain;
		begin
			rx_rdy = 1;
			while (exq.size() > 0) begin
				check({7'h0, rxv}, 8'h01);
				check(rxd, exq.pop_front());
				tick;
			end
			rx_rdy = 0;
		end
	endtask
	task wait_free;
		integer k;
		begin
			k = 0;
			while ((busy !== 1'b0 || brr !== 1'b0) && k < 5000) begin
				tick;
				k = k + 1;
			end
			lim(k, 5000);
		end
	endtask
	// cycles between two releases of the clock wire
	task bit_time(output integer tt);
		integer k;
		reg p;
		begin
			k = 0;
			tt = 0;
			while (k < 2 && tt < 9000) begin
				p = scl_oe;
				tick;
				tt = tt + 1;
				if (p === 1'b1 && scl_oe === 1'b0) begin
					k = k + 1;
					if (k == 1)
						tt = 0;
				end
			end
			lim(tt, 9000);
		end
	endtask
	// ============================================================
	// main sequence
	initial begin
		seed = 32'hf69d440d;
		fail_count = 0;
		samples_checked = 0;
		{rst_n, breq, brel, ack_en, clr, bw, rx_rdy, comp, rate} = 0;
		{en, ack_a, ack_d} = 3'h7;
		bdata = 0;
		n = 0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1;
		check(code, 8'hF8);
		a = $random(seed);
		breq = 1;
		step(0, 0, 0, 8'h08);
		breq = 0;
		step(1, {a[6:0], 1'b0}, 0, 8'h18);
		check(got, {a[6:0], 1'b0});
		for (i = 0; i < 8; i = i + 1) begin
			rate = i;
			ack_d = i < 7;
			d = $random(seed);
			go(1, d, 0);
			bit_time(t);
			wait_flag;
			check(code, i < 7 ? 8'h28 : 8'h30);
			check(got, d);
			check({7'h0, t > bit_cyc(i) - 8 && t < bit_cyc(i) + 8}, 8'h01);
		end
		rate = 0;
		breq = 1;
		step(0, 0, 0, 8'h10);
		breq = 0;
		step(1, {a[6:0], 1'b1}, 0, 8'h40);
		check({7'h0, crx}, 8'h01);
		ack_en = 1;
		rxb(8'h50);
		ack_en = 0;
		rxb(8'h58);
		drain;
		breq = 1;
		step(0, 0, 0, 8'h10);
		breq = 0;
		step(1, {a[6:0], 1'b0}, 0, 8'h18);
		check({7'h0, crx}, 8'h00);
		breq = 1;
		step(0, 0, 1, 8'h08);
		check({7'h0, brr}, 8'h00);
		breq = 0;
		ack_a = 0;
		step(1, {a[6:0], 1'b0}, 0, 8'h20);
		go(0, 0, 1);
		wait_free;
		check(code, 8'hF8);
		breq = 1;
		step(0, 0, 0, 8'h08);
		breq = 0;
		step(1, {a[6:0], 1'b1}, 0, 8'h48);
		go(0, 0, 1);
		wait_free;
		ack_a = 1;
		breq = 1;
		step(0, 0, 0, 8'h08);
		breq = 0;
		go(1, 8'hA4, 0);
		comp = 1; // a second master holds the data wire low
		wait_flag;
		check(code, 8'h38);
		breq = 1;
		go(0, 0, 0);
		repeat (300) tick;
		check({7'h0, flag}, 8'h00);
		comp = 0;
		wait_flag;
		check(code, 8'h08);
		breq = 0;
		n = 0;
		step(1, {a[6:0], 1'b1}, 0, 8'h40);
		ack_en = 1;
		for (i = 0; i < 16; i = i + 1)
			rxb(8'h50);
		go(0, 0, 0);
		repeat (2000) tick;
		check({6'h0, flag, scl_oe}, 8'h01);
		drain;
		rx_wait(8'h50);
		ack_en = 0;
		// second master pulls data low in the not-acknowledge bit
		go(0, 0, 0);
		t = 0;
		for (i = 0; i < 16 && t < 9000; t = t + 1) begin
			if (scl_oe === i[0])
				i = i + 1;
			tick;
		end
		lim(t, 9000);
		comp = 1;
		wait_flag;
		check(code, 8'h38);
		go(0, 0, 0);
		comp = 0;
		wait_free;
		check({6'h0, scl_oe, sda_oe}, 8'h00);
		drain;
		en = 0;
		repeat (3) tick;
		close_out;
	end
endmodule
bind tw_master_seq tw_seq_asserts chk (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .unit_enable_in(unit_enable_in),
	.bus_release_set_in(bus_release_set_in), .flag_clear_in(flag_clear_in),
	.scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out),
	.transfer_event_flag_out(transfer_event_flag_out),
	.bus_release_request_out(bus_release_request_out),
	.bus_state_code_out(bus_state_code_out),
	.controller_receive_out(controller_receive_out),
	.bus_busy_out(bus_busy_out));

//--- tw_seq_asserts.sv
// port checks for the two-wire master sequencer
// assumes it is bound onto tw_master_seq on the core clock
`timescale 1ns/100ps
// ============================================================
// checker
module tw_seq_asserts (
	input wire clk_in,
	input wire reset_n_in,
	input wire unit_enable_in,
	input wire bus_release_set_in,
	input wire flag_clear_in,
	input wire scl_oe_out,
	input wire sda_oe_out,
	input wire transfer_event_flag_out,
	input wire bus_release_request_out,
	input wire [7:0] bus_state_code_out,
	input wire controller_receive_out,
	input wire bus_busy_out
);
	reg fl_d;
	wire ev = transfer_event_flag_out && !fl_d;
	wire [7:0] c = bus_state_code_out;
	wire oe = scl_oe_out || sda_oe_out;
	// flag one cycle late, to find its rising edge
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			fl_d <= 1'b0;
		else
			fl_d <= transfer_event_flag_out;
	end
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// ============================================================
	// assertions
	a_code_on_flag: assert property (
		ev |-> c >= 8'h08 && c <= 8'h58 && c[2:0] == 3'h0)
		else $error("flag set with a bad status code");
	a_code_hold: assert property (
		transfer_event_flag_out && fl_d |-> $stable(c))
		else $error("status code moved while suspended");
	a_bus_held: assert property (
		transfer_event_flag_out && fl_d |-> $stable(scl_oe_out)
		&& $stable(sda_oe_out))
		else $error("bus moved while suspended");
	a_flag_clear: assert property (
		transfer_event_flag_out && flag_clear_in |=> !transfer_event_flag_out)
		else $error("flag not cleared");
	a_release_set: assert property (
		bus_release_set_in |=> bus_release_request_out)
		else $error("release request not set");
	a_stop_frees: assert property (
		$fell(bus_release_request_out) |-> ##[0:4] !oe)
		else $error("release request cleared without stop");
	a_arb_release: assert property (
		ev && c == 8'h38 |-> !oe)
		else $error("bus kept after lost arbitration");
	a_start_held: assert property (
		ev && (c == 8'h08 || c == 8'h10) |-> bus_busy_out && scl_oe_out)
		else $error("start reported without busy bus");
	a_rx_mode: assert property (
		ev && c >= 8'h40 |-> controller_receive_out)
		else $error("receive code outside receive operation");
	a_tx_mode: assert property (
		ev && c >= 8'h18 && c <= 8'h30 |-> !controller_receive_out)
		else $error("transmit code in receive operation");
	a_idle_off: assert property (
		!unit_enable_in |=> !oe)
		else $error("pins driven while disabled");
	c_start: cover property (ev && c == 8'h08);
	c_lost: cover property (ev && c == 8'h38);
	c_last_rx: cover property (ev && c == 8'h58);
endmodule

//--- tw_seq_consts.vh
// constants for the two-wire master state sequencer
// assumes a 20 MHz core clock and an open-drain two-wire bus
// ============================================================
// How it works
// - begin request waits bus free, starts, 08H
// - every flag except 38H suspends bus until flag cleared
// - three rate bits pick master bit rate
// - read address byte sent, acknowledge sampled
// - after 10H send address, read bit selects receive
// - write address after 10H selects transmit
// - write address acked 18H, else 20H; data follows
// - data byte acked 28H, else 30H
// - begin request alone gives repeated start
// - release request gives stop, hardware clears it
// - both requests give stop then start
// - lost arbitration gives 38H, release bus
// - after 38H begin request restarts when free
// - lost during not-acknowledge also gives 38H
// - after 40H/50H receive byte, ack per enable
// - after 48H/58H start, stop, or both
`ifndef TW_SEQ_CONSTS_VH
`define TW_SEQ_CONSTS_VH

// ============================================================
// status codes
`define TW_ST_START 8'h08
`define TW_ST_RSTART 8'h10
`define TW_ST_AW_ACK 8'h18
`define TW_ST_AW_NACK 8'h20
`define TW_ST_DW_ACK 8'h28
`define TW_ST_DW_NACK 8'h30
`define TW_ST_ARB_LOST 8'h38
`define TW_ST_AR_ACK 8'h40
`define TW_ST_AR_NACK 8'h48
`define TW_ST_DR_ACK 8'h50
`define TW_ST_DR_NACK 8'h58
`define TW_ST_IDLE 8'hF8

// ============================================================
// timing: core clock and bit rates in kHz
`define TW_CLK_KHZ 20000
`define TW_RATE0_KHZ 100
`define TW_RATE1_KHZ 80
`define TW_RATE2_KHZ 60
`define TW_RATE3_KHZ 50
`define TW_RATE4_KHZ 40
`define TW_RATE5_KHZ 25
`define TW_RATE6_KHZ 20
`define TW_RATE7_KHZ 10
`define TW_QTR_PER_BIT 4

// ============================================================
// bit phase and counter values
`define TW_Q0 2'h0
`define TW_Q1 2'h1
`define TW_Q2 2'h2
`define TW_Q3 2'h3
`define TW_ACK_BIT 4'h8
`define TW_RW_BIT 0
`define TW_MSB 7

`endif

//--- tw_slave_model.sv
// behavioural slave on the two-wire bus
// assumes resolved wire levels with pull-ups at its inputs
`timescale 1ns/100ps
// ============================================================
// slave model
module tw_slave_model (
	input wire scl_in,
	input wire sda_in,
	input wire ack_addr_in,
	input wire ack_data_in,
	output reg sda_oe_out,
	output reg [7:0] got_out
);
	reg [3:0] cnt;
	reg [7:0] sh;
	reg [7:0] nrd;
	reg [7:0] nb;
	reg rd, first, mack;
	// byte sent back in read operation
	function [7:0] txb(input [7:0] k);
		txb = 8'h35 + 8'h1D * k;
	endfunction
	initial begin
		sda_oe_out = 0;
		cnt = 0;
		rd = 0;
		first = 0;
		nrd = 0;
	end
	// start and stop while the clock is high
	always @(sda_in) begin
		if (scl_in === 1'b1) begin
			cnt = 0;
			first = !sda_in;
			rd = 0;
			nrd = 0;
			sda_oe_out = 0;
		end
	end
	// shift in on the rising clock
	always @(posedge scl_in) begin
		if (cnt < 8)
			sh = {sh[6:0], sda_in};
		else
			mack = !sda_in;
		cnt = cnt + 1;
	end
	// drive only while the clock is low
	always @(negedge scl_in) begin
		if (cnt == 8) begin
			got_out = sh;
			if (first)
				rd = sh[0] & ack_addr_in;
			sda_oe_out = first ? ack_addr_in : !rd && ack_data_in;
		end else if (cnt == 9) begin
			cnt = 0;
			if (rd && !first)
				nrd = nrd + 1;
			if (rd && !first && !mack)
				rd = 0; // released after a not-acknowledge
			first = 0;
			nb = txb(nrd);
			sda_oe_out = rd && !nb[7];
		end else if (rd && !first && cnt < 8) begin
			nb = txb(nrd);
			sda_oe_out = !nb[7 - cnt];
		end
	end
endmodule
